// ### hdl/sfh_defines.svh
`ifndef SFH_DEFINES_SVH
`define SFH_DEFINES_SVH

// host-write buffer depth in bytes
`define SFH_BUF_DEPTH 32
// bit counter positions within a byte
`define SFH_BIT_FIRST 3'h0
`define SFH_BIT_LAST 3'h7
`define SFH_BIT_STEP 3'h1
// status byte field positions
`define SFH_ST_READY 0
`define SFH_ST_CMD_BUSY 1
// byte constants
`define SFH_BYTE_ZERO 8'h00
`define SFH_COUNT_ONE 8'h01

`endif

// ### hdl/sfh_pkg.sv
package sfh_pkg;

  // framing phase of the serial port
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_CMD,
    PH_DATA
  } sfh_phase_e;

endpackage

// ### hdl/sfh_buf_if.sv
`timescale 1ns/10ps
`default_nettype none

interface sfh_buf_if #(
  parameter int WIDTH = 8
);
  logic             w_valid;
  logic             w_ready;
  logic             w_one_left;
  logic [WIDTH-1:0] w_data;
  logic             r_valid;
  logic             r_ready;
  logic [WIDTH-1:0] r_data;

  modport fill (
    output w_valid,
    output w_data,
    output r_ready,
    input  w_ready,
    input  w_one_left,
    input  r_valid,
    input  r_data
  );

  modport store (
    input  w_valid,
    input  w_data,
    input  r_ready,
    output w_ready,
    output w_one_left,
    output r_valid,
    output r_data
  );
endinterface

`default_nettype wire

// ### hdl/sfh_fifo.sv
`include "sfh_defines.svh"
`timescale 1ns/10ps
`default_nettype none

// depth must be a power of two: pointers wrap by overflow
module sfh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `SFH_BUF_DEPTH
) (
  // system
  input  wire logic clk_sys,
  input  wire logic srst,
  // both stream sides
  sfh_buf_if.store  bus
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [CW-1:0]               cnt;
    logic                        ov;
    logic [WIDTH-1:0]            od;
  } sfh_fifo_s;

  sfh_fifo_s s_r;
  sfh_fifo_s s_nxt;
  logic      push;
  logic      pop;
  logic      load;
  logic [CW-1:0] fill;

  // the output register counts as a slot, so the buffer holds DEPTH words
  assign fill           = CW'(s_r.cnt + CW'(s_r.ov));
  assign bus.w_ready    = (fill != CW'(DEPTH));
  assign bus.w_one_left = (fill == CW'(DEPTH - 1));
  assign bus.r_valid    = s_r.ov;
  assign bus.r_data     = s_r.od;

  // read data leave through an output register so the drain sees a flop
  always_comb begin
    s_nxt = s_r;
    push  = bus.w_valid && bus.w_ready;
    pop   = s_r.ov && bus.r_ready;
    load  = (!s_r.ov || pop) && (s_r.cnt != '0);
    if (pop) begin
      s_nxt.ov = 1'b0;
    end
    if (load) begin
      s_nxt.od = s_r.mem[s_r.rd];
      s_nxt.ov = 1'b1;
      s_nxt.rd = PW'(s_r.rd + 1'b1);
    end
    if (push) begin
      s_nxt.mem[s_r.wr] = bus.w_data;
      s_nxt.wr          = PW'(s_r.wr + 1'b1);
    end
    s_nxt.cnt = CW'(s_r.cnt + CW'(push) - CW'(load));
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule // sfh_fifo

`default_nettype wire

// ### hdl/sfh_spi_slave.sv
`include "sfh_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module sfh_spi_slave #(
  parameter int DEPTH = `SFH_BUF_DEPTH
) (
  // system
  input  wire logic       clk_sys,
  input  wire logic       srst,
  // serial pins
  input  wire logic       sclk,
  input  wire logic       select_n,
  input  wire logic       mosi,
  output logic            miso_o,
  output logic            miso_oe,
  output logic            flow_ready_n_busy,
  output logic            alert_n,
  // device state shown in the status byte
  input  wire logic [7:0] core_status,
  input  wire logic       command_busy_flag,
  // decoded command and its reply length
  output logic [7:0]      cmd_byte,
  output logic            cmd_valid,
  input  wire logic [7:0] reply_len,
  // reply bytes from the core
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  // host-written bytes towards the core
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready
);
  typedef struct packed {
    logic                     sclk_m;
    logic                     sclk_q;
    logic                     sclk_p;
    logic                     sel_m;
    logic                     sel_q;
    logic                     sel_p;
    logic                     mosi_m;
    logic                     mosi_q;
    sfh_pkg::sfh_phase_e      phase;
    logic [2:0]               bit_cnt;
    logic [7:0]               rx_sh;
    logic [7:0]               tx_sh;
    logic                     miso;
    logic                     miso_oe;
    logic                     sending;
    logic                     reply_pend;
    logic [7:0]               reply_left;
    logic                     busy_wr;
    logic                     busy_rd;
    logic                     ready_pin;
    logic                     status_rdy;
    logic                     alert_n;
    logic [7:0]               cmd_byte;
    logic                     cmd_valid;
    logic                     tx_ready;
    logic                     w_valid;
    logic [7:0]               w_data;
  } sfh_state_s;

  // pin images reset to the idle bus levels
  localparam sfh_state_s RST = '{
    sclk_m:     1'b1,
    sclk_q:     1'b1,
    sclk_p:     1'b1,
    sel_m:      1'b1,
    sel_q:      1'b1,
    sel_p:      1'b1,
    phase:      sfh_pkg::PH_IDLE,
    ready_pin:  1'b1,
    status_rdy: 1'b1,
    alert_n:    1'b1,
    default:    '0
  };

  sfh_state_s s_r;
  sfh_state_s s_nxt;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       sel_fall;
  logic       busy;
  logic [7:0] byte_in;
  logic [7:0] status_word;
  logic [7:0] avail;
  logic [7:0] next_byte;

  sfh_buf_if #(.WIDTH(8)) buf_if ();

  sfh_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_sys (clk_sys),
    .srst    (srst),
    .bus     (buf_if.store)
  );

  assign buf_if.w_valid = s_r.w_valid;
  assign buf_if.w_data  = s_r.w_data;
  assign buf_if.r_ready = rx_ready;
  assign rx_valid       = buf_if.r_valid;
  assign rx_data        = buf_if.r_data;

  assign miso_o            = s_r.miso;
  assign miso_oe           = s_r.miso_oe;
  assign flow_ready_n_busy = s_r.ready_pin;
  assign alert_n           = s_r.alert_n;
  assign cmd_byte          = s_r.cmd_byte;
  assign cmd_valid         = s_r.cmd_valid;
  assign tx_ready          = s_r.tx_ready;

  // edges are found on the second sync stage only
  assign sclk_rise = !s_r.sclk_p && s_r.sclk_q;
  assign sclk_fall = s_r.sclk_p && !s_r.sclk_q;
  assign sel_fall  = s_r.sel_p && !s_r.sel_q;
  assign busy      = s_r.busy_wr || s_r.busy_rd;
  assign byte_in   = {s_r.rx_sh[6:0], s_r.mosi_q};

  always_comb begin
    status_word                   = core_status;
    status_word[`SFH_ST_READY]    = s_r.status_rdy;
    status_word[`SFH_ST_CMD_BUSY] = command_busy_flag;
  end

  always_comb begin
    s_nxt     = s_r;
    avail     = `SFH_BYTE_ZERO;
    next_byte = `SFH_BYTE_ZERO;

    s_nxt.sclk_m = sclk;
    s_nxt.sclk_q = s_r.sclk_m;
    s_nxt.sclk_p = s_r.sclk_q;
    s_nxt.sel_m  = select_n;
    s_nxt.sel_q  = s_r.sel_m;
    s_nxt.sel_p  = s_r.sel_q;
    s_nxt.mosi_m = mosi;
    s_nxt.mosi_q = s_r.mosi_m;

    s_nxt.cmd_valid = 1'b0;
    s_nxt.tx_ready  = 1'b0;
    s_nxt.w_valid   = 1'b0;

    // a push issued last cycle has not reached the count yet
    if (s_r.busy_wr && buf_if.w_ready && !s_r.w_valid) begin
      s_nxt.busy_wr = 1'b0;
    end
    if (s_r.busy_rd && tx_valid) begin
      s_nxt.busy_rd = 1'b0;
    end

    if (s_r.sel_q) begin
      // deselected: drop any partial byte and release the line
      s_nxt.phase      = sfh_pkg::PH_IDLE;
      s_nxt.bit_cnt    = `SFH_BIT_FIRST;
      s_nxt.miso_oe    = 1'b0;
      s_nxt.sending    = 1'b0;
      s_nxt.reply_pend = 1'b0;
      s_nxt.reply_left = `SFH_BYTE_ZERO;
      s_nxt.busy_wr    = 1'b0;
      s_nxt.busy_rd    = 1'b0;
    end else if (sel_fall) begin
      s_nxt.phase      = sfh_pkg::PH_CMD;
      s_nxt.bit_cnt    = `SFH_BIT_FIRST;
      s_nxt.miso_oe    = 1'b1;
      s_nxt.tx_sh      = status_word;
      s_nxt.miso       = status_word[7];
      // a cleared ready bit is shown once, then rearmed
      s_nxt.status_rdy = 1'b1;
      s_nxt.alert_n    = 1'b1;
    end else if (busy) begin
      // the host should be holding the clock high here
      if (sclk_rise) begin
        s_nxt.status_rdy = 1'b0;
      end
    end else begin
      if (sclk_fall) begin
        if (s_r.phase == sfh_pkg::PH_DATA
            && s_r.bit_cnt == `SFH_BIT_FIRST) begin
          // reply length is taken at the first falling edge after the
          // command, giving the core half a clock period to decode it
          avail            = s_r.reply_pend ? reply_len : s_r.reply_left;
          s_nxt.reply_pend = 1'b0;
          if (avail != `SFH_BYTE_ZERO) begin
            s_nxt.reply_left = avail - `SFH_COUNT_ONE;
            s_nxt.sending    = 1'b1;
            if (tx_valid) begin
              next_byte      = tx_data;
              s_nxt.tx_ready = 1'b1;
            end else begin
              s_nxt.alert_n = 1'b0;
            end
          end else begin
            s_nxt.sending = 1'b0;
          end
          s_nxt.miso  = next_byte[7];
          s_nxt.tx_sh = {next_byte[6:0], 1'b0};
        end else begin
          s_nxt.miso  = s_r.tx_sh[7];
          s_nxt.tx_sh = {s_r.tx_sh[6:0], 1'b0};
        end
      end
      if (sclk_rise && s_r.phase != sfh_pkg::PH_IDLE) begin
        s_nxt.rx_sh   = byte_in;
        s_nxt.bit_cnt = s_r.bit_cnt + `SFH_BIT_STEP;
        if (s_r.bit_cnt == `SFH_BIT_LAST) begin
          if (s_r.phase == sfh_pkg::PH_CMD) begin
            s_nxt.cmd_byte   = byte_in;
            s_nxt.cmd_valid  = 1'b1;
            s_nxt.phase      = sfh_pkg::PH_DATA;
            s_nxt.reply_pend = 1'b1;
            s_nxt.sending    = 1'b0;
          end else if (!s_r.sending) begin
            // host-written byte; bytes that overlap a reply are dropped
            if (buf_if.w_ready) begin
              s_nxt.w_valid = 1'b1;
              s_nxt.w_data  = byte_in;
              if (buf_if.w_one_left) begin
                s_nxt.busy_wr = 1'b1;
              end
            end else begin
              s_nxt.alert_n = 1'b0;
            end
          end else if (s_r.reply_left != `SFH_BYTE_ZERO && !tx_valid) begin
            s_nxt.busy_rd = 1'b1;
          end
        end
      end
    end

    // host must stop clocking while this pin is low
    s_nxt.ready_pin = !(s_nxt.busy_wr || s_nxt.busy_rd);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_r <= RST;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule // sfh_spi_slave

`default_nettype wire

// ### tb/sfh_spi_monitor.sv
`timescale 1ns/10ps
`default_nettype none

module sfh_spi_monitor (
  // system
  input wire logic       clk_sys,
  input wire logic       srst,
  // pins
  input wire logic       sclk,
  input wire logic       select_n,
  input wire logic       miso_o,
  input wire logic       miso_oe,
  input wire logic       flow_ready_n_busy,
  input wire logic       alert_n,
  // core side
  input wire logic [7:0] cmd_byte,
  input wire logic       cmd_valid,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic [7:0] rx_data,
  input wire logic       rx_valid,
  input wire logic       rx_ready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // five samples cover the three cycle pin latency with margin
  sequence s_idle; select_n [*5]; endsequence
  sequence s_framed; !select_n [*5]; endsequence
  sequence s_pulse; cmd_valid ##1 !cmd_valid; endsequence

  AST_OE_OFF: assert property (s_idle |-> !miso_oe)
    else $error("miso driven while deselected");
  AST_OE_ON: assert property (s_framed |-> miso_oe)
    else $error("miso not driven in frame");
  AST_MISO_STEP: assert property (!select_n && $past(miso_oe)
    && $changed(miso_o) |-> !$past(sclk, 2)) else $error("miso moved early");
  AST_BUSY_AT_RISE: assert property ($fell(flow_ready_n_busy)
    && tx_valid |-> $past(sclk, 2)) else $error("busy without clock rise");
  AST_CMD_PULSE: assert property (cmd_valid |-> s_pulse)
    else $error("command strobe too long");
  AST_CMD_HOLD: assert property ($changed(cmd_byte) |-> cmd_valid)
    else $error("command changed without strobe");
  AST_CMD_FRAMED: assert property (cmd_valid |-> !select_n)
    else $error("command outside frame");
  AST_TX_TAKEN: assert property (tx_ready
    |-> $past(tx_valid) ##1 !tx_ready)
    else $error("reply taken without valid");
  AST_ALERT_STICKY: assert property (!alert_n && select_n |=> !alert_n)
    else $error("alert cleared outside frame start");
  AST_RX_HOLD: assert property (rx_valid && !rx_ready
    |=> rx_valid && $stable(rx_data)) else $error("rx data dropped");
endmodule // sfh_spi_monitor

bind sfh_spi_slave sfh_spi_monitor u_mon (.clk_sys, .srst, .sclk, .select_n,
  .miso_o, .miso_oe, .flow_ready_n_busy, .alert_n, .cmd_byte, .cmd_valid,
  .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready);

`default_nettype wire

// ### tb/sfh_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module sfh_host_model (
  // system
  input  wire logic clk_sys,
  // serial pins
  output var logic  sclk,
  output var logic  select_n,
  output var logic  mosi,
  input  wire logic miso,
  input  wire logic flow_ready_n_busy
);
  logic ignore_busy;

  // clock stands high outside frames
  initial begin
    sclk = 1'b1;
    select_n = 1'b1;
    mosi = 1'b0;
    ignore_busy = 1'b0;
  end

  task automatic frame_open();
    select_n = 1'b0;
    #125;
  endtask

  task automatic frame_close();
    #60;
    select_n = 1'b1;
    mosi = ~mosi;
    #125;
  endtask

  // ignore_busy breaks the handshake on purpose
  task automatic xfer(input logic [7:0] b, input int n,
                      output logic [7:0] r);
    int j;
    r = 8'h00;
    j = 0;
    #40;
    while (!ignore_busy && flow_ready_n_busy !== 1'b1 && j < 5000) begin
      #10;
      j++;
    end
    for (int i = 7; i > 7 - n; i--) begin
      sclk = 1'b0;
      mosi = b[i];
      #62.5;
      sclk = 1'b1;
      r[i] = miso;
      #62.5;
    end
  endtask
endmodule // sfh_host_model

`default_nettype wire

// ### tb/spi_slave_flow_handshake_test.sv
`timescale 1ns/10ps
`default_nettype none

module spi_slave_flow_handshake_test;
  logic       clk_sys, srst, sclk, select_n, mosi, miso, miso_o, miso_oe;
  logic       flow_ready_n_busy, alert_n, command_busy_flag, cmd_valid;
  logic       tx_valid, tx_ready, rx_valid, rx_ready;
  logic [7:0] core_status, cmd_byte, reply_len, tx_data, rx_data, got, exp_rx;
  int         n_errors, n_checks, n_rx, cycles;

  // a released line reads inverted so a stale bit cannot pass
  assign miso = miso_oe ? miso_o : ~miso_o;

  sfh_spi_slave #(.DEPTH(32)) u_dut (.clk_sys, .srst, .sclk, .select_n,
    .mosi, .miso_o, .miso_oe, .flow_ready_n_busy, .alert_n, .core_status,
    .command_busy_flag, .cmd_byte, .cmd_valid, .reply_len, .tx_data,
    .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready);
  sfh_host_model u_host (.clk_sys, .sclk, .select_n, .mosi, .miso,
    .flow_ready_n_busy);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (n_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // core: reply counter and drain checker; mid-cycle so outputs have settled
  always @(negedge clk_sys) begin
    cycles <= cycles + 1;
    if (tx_ready) tx_data <= tx_data + 8'h01;
    if (rx_valid && rx_ready) begin
      check("rx_data", rx_data, exp_rx);
      exp_rx <= exp_rx + 8'h01;
      n_rx <= n_rx + 1;
    end
    if (cycles == 30000) begin
      n_errors++;
      end_of_test();
    end
  end

  // the core stalls the second reply byte to force a busy wait
  task automatic sc_status_reply();
    u_host.frame_open();
    u_host.xfer(8'hc5, 8, got);
    check("status", got, 8'ha7);
    check("cmd_byte", cmd_byte, 8'hc5);
    fork
      begin
        @(posedge tx_ready);
        #1 tx_valid = 1'b0;
        repeat (120) @(posedge clk_sys);
        #1 tx_valid = 1'b1;
      end
    join_none
    u_host.ignore_busy = 1'b1;
    #2000;
    u_host.xfer(8'h00, 8, got);
    u_host.ignore_busy = 1'b0;
    check("reply0", got, 8'h3c);
    check("busy_rd", {7'h00, flow_ready_n_busy}, 8'h00);
    u_host.xfer(8'h00, 8, got);
    check("reply1", got, 8'h3d);
    check("alert_n", {7'h00, alert_n}, 8'h01);
    u_host.frame_close();
  endtask

  task automatic sc_fill_refuse();
    reply_len = 8'h00;
    u_host.frame_open();
    u_host.xfer(8'h5a, 8, got);
    for (int k = 0; k < 32; k++) u_host.xfer(8'h10 + k[7:0], 8, got);
    repeat (6) @(posedge clk_sys);
    check("busy_full", {7'h00, flow_ready_n_busy}, 8'h00);
    u_host.ignore_busy = 1'b1;
    u_host.xfer(8'hee, 8, got);
    u_host.ignore_busy = 1'b0;
    u_host.frame_close();
    @(posedge clk_sys) #1 rx_ready = 1'b1;
    for (int j = 0; j < 300 && n_rx < 32; j++) @(posedge clk_sys);
    repeat (8) @(posedge clk_sys);
    check("drained", n_rx[7:0], 8'h20);
    check("ready_back", {7'h00, flow_ready_n_busy}, 8'h01);
    check("rx_empty", {7'h00, rx_valid}, 8'h00);
  endtask

  task automatic sc_partial_status();
    u_host.frame_open();
    u_host.xfer(8'h36, 8, got);
    check("status_refused", got, 8'ha6);
    u_host.frame_close();
    u_host.frame_open();
    u_host.xfer(8'hff, 3, got);
    u_host.frame_close();
    command_busy_flag = 1'b0;
    reply_len = 8'h01;
    tx_valid = 1'b0;
    u_host.frame_open();
    u_host.xfer(8'h69, 8, got);
    check("idle_status", got, 8'ha5);
    check("cmd_after_cut", cmd_byte, 8'h69);
    u_host.xfer(8'h00, 8, got);
    check("reply_gap", got, 8'h00);
    check("alert_low", {7'h00, alert_n}, 8'h00);
    u_host.frame_close();
    tx_valid = 1'b1;
    check("miso_oe", {7'h00, miso_oe}, 8'h00);
  endtask

  initial begin
    srst = 1'b1;
    core_status = 8'ha4;
    command_busy_flag = 1'b1;
    reply_len = 8'h02;
    tx_data = 8'h3c;
    tx_valid = 1'b1;
    rx_ready = 1'b0;
    exp_rx = 8'h10;
    n_rx = 0;
    n_errors = 0;
    n_checks = 0;
    cycles = 0;
    repeat (20) @(posedge clk_sys);
    #1 srst = 1'b0;
    repeat (3) @(posedge clk_sys);
    sc_status_reply();
    sc_fill_refuse();
    sc_partial_status();
    end_of_test();
  end
endmodule // spi_slave_flow_handshake_test

`default_nettype wire
